// *** rtl/ndi_init.sv ***
// NAND flash discovery and initialization sequencer with AXI4-Lite registers
// Behaviour
// - one flash device, 8 or 16 bit bus
// - four chip enables; dedicated pins use first only
// - flash strobes at most 50 MHz, programmable
// - 32 to 512 pages per block accepted
// - page sizes 512, 2K, 4K, 8K
// - ECC sectors 512 (4/8/16) or 1024 (24)
// - straps sampled on release from reset
// - skip strap bypasses query and first page
// - small-page-wide strap means 16-bit small page
// - short-row strap gives two row cycles
// - no-load strap omits block 0 page 0
// - skip strap jumps to final reset
// - Read ID checks for ONFI signature
// - ONFI part: read parameter page, keep values
// - otherwise legacy: reset, read signature, keep
// - reset device and detect bus width
// - load block 0 page 0 for direct read
// - final reset then set reset-complete flag
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module ndi_init (
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic skip_init_strap, // Skip discovery
  input wire logic small_page_strap, // 512-byte page part
  input wire logic small_page_wide_strap, // 512-byte page, 16-bit bus
  input wire logic short_row_strap, // Two row address cycles
  input wire logic no_first_page_load_strap, // Omit block 0 page 0 load
  input wire logic dedicated_pins, // Interface on dedicated pins
  input wire logic [15:0] nand_adq_i, // Flash data in
  output logic [15:0] nand_adq_o, // Flash data out
  output logic nand_adq_oe_n, // Data drive enable, low drives
  output logic nand_ale, // Address latch enable
  output logic nand_cle, // Command latch enable
  output logic nand_we_n, // Write strobe, active low
  output logic nand_re_n, // Read strobe, active low
  output logic [3:0] nand_ce_n, // Chip enables, active low
  output logic nand_wp_n, // Write protect, active low
  input wire logic [3:0] nand_rdy_busy // Ready high, busy low
);
  import ndi_pkg::*;

  // Whole state of the block
  typedef struct packed {
    ndi_state_t st;
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [2:0] wcnt;
    logic [6:0] bcnt;
    logic [23:0] sig;
    logic [7:0] rbyte;
    logic [7:0] pbyte;
    logic [4:0] strap;
    logic onfi;
    logic legacy;
    logic width16;
    logic done;
    logic rst_comp;
    logic [1:0] page_code;
    logic [9:0] ppb;
    logic [3:0] tw;
    logic [1:0] ce_sel;
    logic wp_off;
    logic ecc_1k;
    logic [1:0] ecc_str;
    logic dr_ok;
    logic dr_req;
    logic dr_valid;
    logic [7:0] dr_data;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] adq_o;
    logic adq_oe_n;
    logic ale;
    logic cle;
    logic we_n;
    logic re_n;
    logic [3:0] ce_n;
  } ndi_regs_t;

  ndi_regs_t r; // Registered state
  ndi_regs_t n; // Next state
  logic rdy; // Ready of the selected chip
  logic fin; // Strobe operation ends this cycle
  logic [1:0] op_kind; // Operation asked by the sequencer
  logic [7:0] op_byte; // Byte sent by that operation
  logic wr_go; // Register write performed
  logic rd_go; // Register read performed
  logic [6:0] b0_last; // Last address cycle of the page load

  // Legal pages-per-block values
  function automatic logic ppb_ok(input logic [9:0] v);
    return (v == 10'h020) || (v == 10'h040) || (v == 10'h080) ||
      (v == 10'h100) || (v == 10'h180) || (v == 10'h200);
  endfunction

  // sequencing depends on the connected ready/busy pin
  assign rdy = nand_rdy_busy[r.ce_sel];
  assign fin = (r.ph == PH_HI) && (r.cnt == 4'h0);
  // two row cycles when the short-row strap is set
  assign b0_last = (r.strap[STRAP_SMALL] ? 7'h1 : 7'h2) +
    (r.strap[STRAP_SHORT] ? 7'h1 : 7'h2);

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign nand_adq_o = r.adq_o;
  assign nand_adq_oe_n = r.adq_oe_n;
  assign nand_ale = r.ale;
  assign nand_cle = r.cle;
  assign nand_we_n = r.we_n;
  assign nand_re_n = r.re_n;
  assign nand_ce_n = r.ce_n;
  assign nand_wp_n = r.wp_off;

  // Operation each sequencer state asks of the strobe engine
  always_comb begin
    op_kind = OP_NONE;
    op_byte = 8'h00;
    case (r.st)
      ST_ID_CMD, ST_LG_CMD: begin
        op_kind = OP_CMD;
        op_byte = CMD_READ_ID;
      end
      ST_ID_ADR: begin
        op_kind = OP_ADR;
        op_byte = ADR_ONFI_ID;
      end
      ST_PP_CMD: begin
        op_kind = OP_CMD;
        op_byte = CMD_PARAM;
      end
      ST_PP_ADR, ST_LG_ADR, ST_B0_ADR: begin
        op_kind = OP_ADR;
        op_byte = 8'h00;
      end
      ST_LG_RST, ST_DR_RST, ST_FN_RST: begin
        op_kind = OP_CMD;
        op_byte = CMD_RESET;
      end
      ST_B0_CMD: begin
        op_kind = OP_CMD;
        op_byte = CMD_READ;
      end
      ST_B0_CFM: begin
        op_kind = OP_CMD;
        op_byte = CMD_READ_GO;
      end
      ST_ID_RD, ST_PP_RD, ST_LG_RD: begin
        op_kind = OP_RD;
      end
      ST_DONE: begin
        // direct read fetches one byte per request
        if (r.dr_req) begin
          op_kind = OP_RD;
        end
      end
      default: begin
        op_kind = OP_NONE;
      end
    endcase
  end

  // Next-state logic for sequencer, strobe engine and register port
  always_comb begin
    n = r;
    wr_go = 1'b0;
    rd_go = 1'b0;
    // Strobe engine: low phase then high phase, tw cycles each
    case (r.ph)
      PH_IDLE: begin
        if (op_kind != OP_NONE) begin
          // tw of at least one cycle keeps strobes under 50 MHz
          n.ph = PH_LO;
          n.cnt = r.tw - 4'h1;
          n.cle = (op_kind == OP_CMD);
          n.ale = (op_kind == OP_ADR);
          n.we_n = (op_kind == OP_RD);
          n.re_n = (op_kind != OP_RD);
          n.adq_o = {8'h00, op_byte};
          n.adq_oe_n = (op_kind == OP_RD);
        end
      end
      PH_LO: begin
        if (r.cnt == 4'h0) begin
          // Sample read data just before the strobe rises
          n.ph = PH_HI;
          n.cnt = r.tw - 4'h1;
          n.we_n = 1'b1;
          n.re_n = 1'b1;
          n.rbyte = nand_adq_i[7:0];
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      PH_HI: begin
        if (r.cnt == 4'h0) begin
          n.ph = PH_IDLE;
          n.cle = 1'b0;
          n.ale = 1'b0;
          n.adq_oe_n = 1'b1;
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      default: begin
        n.ph = PH_IDLE;
      end
    endcase
    if (fin) begin
      n.wcnt = TWB_CYC;
      n.bcnt = r.bcnt + 7'h1;
      n.pbyte = r.rbyte;
    end
    // Sequencer
    case (r.st)
      ST_SAMPLE: begin
        // straps caught once, first cycle after release
        n.strap = {no_first_page_load_strap, short_row_strap,
          small_page_wide_strap, small_page_strap, skip_init_strap};
        n.wcnt = TWB_CYC;
        // wide strap counts only with a small-page part
        n.width16 = small_page_wide_strap && small_page_strap;
        // skip goes straight to the final reset
        n.st = skip_init_strap ? ST_FN_RST : ST_WAIT0;
      end
      ST_WAIT0: begin
        if (r.wcnt != 3'h0) begin
          n.wcnt = r.wcnt - 3'h1;
        end else if (rdy) begin
          // Small-page parts ignore Read ID, so take them as legacy
          n.legacy = r.strap[STRAP_SMALL];
          n.page_code = PAGE_512;
          n.ppb = PPB_RST;
          n.st = r.strap[STRAP_SMALL] ? ST_DR_RST : ST_ID_CMD;
        end
      end
      ST_ID_CMD: if (fin) n.st = ST_ID_ADR;
      ST_ID_ADR: begin
        if (fin) begin
          n.st = ST_ID_RD;
          n.bcnt = 7'h0;
        end
      end
      ST_ID_RD: begin
        if (fin) begin
          n.sig = {r.sig[15:0], r.rbyte};
          if (r.bcnt == ID_LAST) begin
            n.onfi = ({r.sig, r.rbyte} == ONFI_SIG);
            n.legacy = !n.onfi;
            n.st = n.onfi ? ST_PP_CMD : ST_LG_RST;
          end
        end
      end
      ST_PP_CMD: if (fin) n.st = ST_PP_ADR;
      ST_PP_ADR: if (fin) n.st = ST_PP_WAIT;
      ST_PP_WAIT, ST_LG_WAIT, ST_DR_WAIT, ST_B0_WAIT, ST_FN_WAIT: begin
        if (r.wcnt != 3'h0) begin
          n.wcnt = r.wcnt - 3'h1;
        end else if (rdy) begin
          n.bcnt = 7'h0;
          case (r.st)
            ST_PP_WAIT: n.st = ST_PP_RD;
            ST_LG_WAIT: n.st = ST_LG_CMD;
            // no-load strap skips the first page
            ST_DR_WAIT: begin
              n.st = r.strap[STRAP_NOLOAD] ? ST_FN_RST : ST_B0_CMD;
            end
            ST_B0_WAIT: begin
              n.dr_ok = 1'b1;
              n.st = ST_FN_RST;
            end
            default: begin
              // flag set once the final reset is over
              n.done = 1'b1;
              n.rst_comp = 1'b1;
              n.st = ST_DONE;
            end
          endcase
        end
      end
      ST_PP_RD: begin
        if (fin) begin
          // keep width, page size and block size
          if (r.bcnt == PP_FEAT) n.width16 = r.rbyte[0];
          // page size code from the high size byte
          if (r.bcnt == PP_PAGE_HI) begin
            n.page_code = r.rbyte[5] ? PAGE_8K : r.rbyte[4] ? PAGE_4K :
              r.rbyte[3] ? PAGE_2K : PAGE_512;
          end
          if (r.bcnt == PP_PPB_HI) begin
            n.ppb = ppb_ok({r.rbyte[1:0], r.pbyte}) ?
              {r.rbyte[1:0], r.pbyte} : PPB_RST;
            n.st = ST_DR_RST;
          end
        end
      end
      ST_LG_RST: if (fin) n.st = ST_LG_WAIT;
      ST_LG_CMD: if (fin) n.st = ST_LG_ADR;
      ST_LG_ADR: begin
        if (fin) begin
          n.st = ST_LG_RD;
          n.bcnt = 7'h0;
        end
      end
      ST_LG_RD: begin
        if (fin && r.bcnt == ID_LAST) begin
          // legacy signature gives page, block and width
          n.page_code = (r.rbyte[1:0] == 2'h0) ? PAGE_2K : r.rbyte[1:0];
          n.ppb = 10'((10'h040 << r.rbyte[5:4]) >> n.page_code);
          n.width16 = r.rbyte[6];
          n.st = ST_DR_RST;
        end
      end
      ST_DR_RST: begin
        // width checked while the device resets
        if (fin) begin
          n.st = ST_DR_WAIT;
          if (r.strap[STRAP_SMALL]) n.width16 = r.strap[STRAP_WIDE];
        end
      end
      ST_B0_CMD: begin
        if (fin) begin
          n.st = ST_B0_ADR;
          n.bcnt = 7'h0;
        end
      end
      ST_B0_ADR: begin
        if (fin && r.bcnt == b0_last) begin
          n.st = r.strap[STRAP_SMALL] ? ST_B0_WAIT : ST_B0_CFM;
        end
      end
      ST_B0_CFM: if (fin) n.st = ST_B0_WAIT;
      ST_FN_RST: if (fin) n.st = ST_FN_WAIT;
      ST_DONE: begin
        if (fin) begin
          n.dr_data = r.rbyte;
          n.dr_valid = 1'b1;
          n.dr_req = 1'b0;
        end
      end
      default: n.st = ST_SAMPLE;
    endcase
    // Register write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      wr_go = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.awaddr)
        OFS_CTRL: begin
          if (r.wstrb[0]) begin
            // dedicated pins leave only the first enable
            // hence a single pair when on dedicated pins
            n.ce_sel = dedicated_pins ? 2'h0 : r.wdata[1:0];
            n.wp_off = r.wdata[CTRL_WP_OFF];
          end
        end
        OFS_TIMING: begin
          // zero would break the strobe, kept at one
          if (r.wstrb[0]) begin
            n.tw = (r.wdata[3:0] == 4'h0) ? TW_RST : r.wdata[3:0];
          end
        end
        OFS_INTR: begin
          // Write one to clear; a set in the same cycle wins
          if (r.wstrb[0] && r.wdata[INTR_RST_COMP] &&
              !(r.st == ST_FN_WAIT && n.st == ST_DONE)) begin
            n.rst_comp = 1'b0;
          end
        end
        OFS_GEOM: begin
          if (r.wstrb[0]) begin
            n.page_code = r.wdata[1:0];
            n.width16 = r.wdata[GEOM_WIDTH16];
          end
          if (r.wstrb[1] && r.wstrb[2] &&
              ppb_ok(r.wdata[GEOM_PPB_LSB +: 10])) begin
            n.ppb = r.wdata[GEOM_PPB_LSB +: 10];
          end
        end
        OFS_ECC: begin
          // 1024-byte sectors always use 24-bit strength
          if (r.wstrb[0]) begin
            n.ecc_1k = r.wdata[0] || (r.wdata[2:1] == ECC_STR_24);
            n.ecc_str = r.wdata[0] ? ECC_STR_24 :
              (r.wdata[2:1] == ECC_STR_24) ? ECC_STR_24 : r.wdata[2:1];
          end
        end
        OFS_STATUS, OFS_DRDATA: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    // Register read, answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rd_go = 1'b1;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CTRL: n.rdata = {29'h0, r.wp_off, r.ce_sel};
        OFS_TIMING: n.rdata = {28'h0, r.tw};
        OFS_STATUS: begin
          n.rdata = {11'h0, 5'(r.st), 3'h0, r.strap, 2'h0, r.dr_valid,
            r.dr_ok, r.width16, r.legacy, r.onfi, r.done};
        end
        OFS_INTR: n.rdata = {31'h0, r.rst_comp};
        OFS_GEOM: begin
          n.rdata = {14'h0, r.ppb, r.width16, 5'h0, r.page_code};
        end
        OFS_DRDATA: begin
          // Reading takes the byte and starts the next fetch
          n.rdata = {23'h0, r.dr_valid, r.dr_data};
          n.dr_valid = (r.st == ST_DONE) && fin;
          n.dr_req = r.dr_ok;
        end
        OFS_ECC: n.rdata = {29'h0, r.ecc_str, r.ecc_1k};
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    // selected chip enabled once the sequencer runs
    n.ce_n = (r.st == ST_SAMPLE) ? 4'hF : ~(4'h1 << n.ce_sel);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= ST_SAMPLE;
      r.tw <= TW_RST;
      r.ppb <= PPB_RST;
      r.adq_oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.re_n <= 1'b1;
      r.ce_n <= 4'hF;
      r.strap[STRAP_NOLOAD] <= 1'b1;
    end else begin
      r <= n;
    end
  end
endmodule // ndi_init

// *** rtl/ndi_pkg.sv ***
// Constants and types for the NAND discovery and initialization sequencer
package ndi_pkg;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INTR = 8'h0C;
  localparam logic [7:0] OFS_GEOM = 8'h10;
  localparam logic [7:0] OFS_DRDATA = 8'h14;
  localparam logic [7:0] OFS_ECC = 8'h18;
  // Field positions
  localparam int CTRL_WP_OFF = 2;
  localparam int INTR_RST_COMP = 0;
  localparam int GEOM_WIDTH16 = 7;
  localparam int GEOM_PPB_LSB = 8;
  localparam int STRAP_SKIP = 0;
  localparam int STRAP_SMALL = 1;
  localparam int STRAP_WIDE = 2;
  localparam int STRAP_SHORT = 3;
  localparam int STRAP_NOLOAD = 4;
  // Reset values, page size codes and ECC strength codes
  localparam logic [3:0] TW_RST = 4'h1;
  localparam logic [1:0] PAGE_512 = 2'h0;
  localparam logic [1:0] PAGE_2K = 2'h1;
  localparam logic [1:0] PAGE_4K = 2'h2;
  localparam logic [1:0] PAGE_8K = 2'h3;
  localparam logic [9:0] PPB_RST = 10'h020;
  localparam logic [1:0] ECC_STR_4 = 2'h0;
  localparam logic [1:0] ECC_STR_16 = 2'h2;
  localparam logic [1:0] ECC_STR_24 = 2'h3;
  // Flash commands, the ONFI Read ID address and the identification signature
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PARAM = 8'hEC;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] ADR_ONFI_ID = 8'h20;
  localparam logic [31:0] ONFI_SIG = 32'h4F4E4649;
  // Parameter page byte indices that are kept, and the last Read ID byte index
  localparam logic [6:0] PP_FEAT = 7'h06;
  localparam logic [6:0] PP_PAGE_HI = 7'h51;
  localparam logic [6:0] PP_PPB_LO = 7'h5C;
  localparam logic [6:0] PP_PPB_HI = 7'h5D;
  localparam logic [6:0] ID_LAST = 7'h03;
  // Timing: clock period, busy-flag settle time, fastest flash rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int TWB_NS = 200;
  localparam int TWB_CYC_I = (TWB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TWB_CYC = 3'(TWB_CYC_I);
  localparam int FLASH_MAX_MHZ = 50;
  // Flash strobe engine phases, operation kinds and AXI4-Lite responses
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_LO = 2'h1;
  localparam logic [1:0] PH_HI = 2'h2;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_CMD = 2'h1;
  localparam logic [1:0] OP_ADR = 2'h2;
  localparam logic [1:0] OP_RD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_SAMPLE, ST_WAIT0, ST_ID_CMD, ST_ID_ADR, ST_ID_RD,
    ST_PP_CMD, ST_PP_ADR, ST_PP_WAIT, ST_PP_RD,
    ST_LG_RST, ST_LG_WAIT, ST_LG_CMD, ST_LG_ADR, ST_LG_RD,
    ST_DR_RST, ST_DR_WAIT, ST_B0_CMD, ST_B0_ADR, ST_B0_CFM, ST_B0_WAIT,
    ST_FN_RST, ST_FN_WAIT, ST_DONE
  } ndi_state_t;
endpackage

// *** tb/ndi_init_checker.sv ***
// Port checker for the discovery sequencer
`timescale 1ns/1ps
module ndi_init_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic [1:0] s_axi_bresp, // Write resp
  input wire logic s_axi_bvalid, // Write resp valid
  input wire logic s_axi_bready, // Write resp ready
  input wire logic s_axi_arvalid, // Read addr valid
  input wire logic s_axi_arready, // Read addr ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic skip_init_strap, // Skip strap
  input wire logic no_first_page_load_strap, // No-load strap
  input wire logic dedicated_pins, // Dedicated pins
  input wire logic [15:0] nand_adq_o, // Flash data out
  input wire logic nand_adq_oe_n, // Drive enable, low
  input wire logic nand_ale, // Address latch
  input wire logic nand_cle, // Command latch
  input wire logic nand_we_n, // Write strobe
  input wire logic nand_re_n, // Read strobe
  input wire logic [3:0] nand_ce_n, // Chip enables
  input wire logic [3:0] nand_rdy_busy // Ready, busy low
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_REL_IDLE: assert property (
    $rose(aresetn) |-> nand_ce_n == 4'hF && nand_we_n && nand_adq_oe_n)
    else $error("Flash pins active at reset release");
  AST_CMD_DRIVE: assert property (
    nand_cle && !nand_we_n |-> !nand_adq_oe_n && !nand_ale)
    else $error("Command strobe without bus drive");
  AST_RD_FREE: assert property (
    !nand_re_n |-> nand_adq_oe_n && nand_we_n)
    else $error("Bus driven during a read strobe");
  AST_ONE_CE: assert property (
    dedicated_pins && nand_ce_n != 4'hF |-> nand_ce_n == 4'hE)
    else $error("Second chip enable on dedicated pins");
  AST_SKIP_RST: assert property (
    skip_init_strap && nand_cle && !nand_we_n |-> nand_adq_o[7:0] == 8'hFF)
    else $error("Discovery command while skipping");
  AST_NO_LOAD: assert property (
    no_first_page_load_strap && nand_cle && !nand_we_n
      |-> nand_adq_o[7:0] != 8'h30)
    else $error("First page loaded despite strap");
  AST_BUSY_WAIT: assert property (
    !nand_rdy_busy[0] && !nand_ce_n[0] |-> nand_we_n && nand_re_n)
    else $error("Strobe while flash busy");
  AST_AR_ANS: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
endmodule // ndi_init_checker

bind ndi_init ndi_init_checker u_ndi_init_checker (.aclk, .aresetn,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .skip_init_strap, .no_first_page_load_strap, .dedicated_pins,
  .nand_adq_o, .nand_adq_oe_n, .nand_ale, .nand_cle, .nand_we_n,
  .nand_re_n, .nand_ce_n, .nand_rdy_busy);

// *** tb/ndi_flash_model.sv ***
// Behavioural flash part answering the discovery sequence
`timescale 1ns/1ps
module ndi_flash_model
  import ndi_pkg::*;
(
  input wire logic aclk, // Bench clock
  input wire logic aresetn, // Bench reset
  input wire logic onfi_m, // Answer with signature
  input wire logic ce_n, // Chip enable 0
  input wire logic cle, // Command latch
  input wire logic ale, // Address latch
  input wire logic we_n, // Write strobe
  input wire logic re_n, // Read strobe
  input wire logic [7:0] dq_o, // Controller data
  output logic [15:0] dq_i, // Data to controller
  output logic [3:0] rdy, // Ready, busy low
  output logic [7:0] cmd_cnt, // Commands taken
  output logic [7:0] adr_b0 // Address cycles before confirm
);
  logic we_q, re_q;
  logic [7:0] cmd, aval, adr, idx, last, bsy, dout;
  assign dout = (cmd == 8'h90 && aval == 8'h20 && onfi_m) ?
    ONFI_SIG[8*(3-int'(idx[1:0])) +: 8] : 8'h00;
  // No pull resistor: released bus shows the inverse of the last byte
  assign dq_i = {8'hFF, (!re_n && !ce_n) ? dout : ~last};
  // one ready pair feeds all inputs
  assign rdy = {4{bsy == 8'h00}};
  // Strobe decode; busy is long after an odd command count, short after an even one
  always_ff @(posedge aclk) begin
    we_q <= we_n;
    re_q <= re_n;
    if (!re_n) last <= dout;
    if (!aresetn) begin
      {cmd_cnt, adr_b0, bsy, cmd, idx, adr, aval, last} <= '0;
    end else begin
      if (bsy != 8'h00) bsy <= bsy - 8'h01;
      if (re_n && !re_q) idx <= idx + 8'h01;
      if (we_n && !we_q && !ce_n && cle) begin
        cmd <= dq_o;
        cmd_cnt <= cmd_cnt + 8'h01;
        idx <= 8'h00;
        adr <= 8'h00;
        if (dq_o == 8'hFF || dq_o == 8'h30) bsy <= cmd_cnt[0] ? 8'd40 : 8'd3;
        if (dq_o == 8'h30) adr_b0 <= adr;
      end
      if (we_n && !we_q && !ce_n && ale) begin
        aval <= dq_o;
        adr <= adr + 8'h01;
        if (cmd == 8'hEC) bsy <= 8'd20;
      end
    end
  end
endmodule // ndi_flash_model

// *** tb/ndi_init_tb.sv ***
// Self-checking bench for the discovery sequencer
`timescale 1ns/1ps
module ndi_init_tb;
  import ndi_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, onfi_m = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, nand_adq_oe_n, nand_ale, nand_cle, nand_we_n;
  logic nand_re_n, nand_wp_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] nand_adq_i, nand_adq_o;
  logic [3:0] nand_ce_n, nand_rdy_busy;
  logic [4:0] st = 5'h10; // Straps: skip, small, wide, short, noload
  logic [7:0] cmd_cnt, adr_b0;
  logic [31:0] d;
  int error_cnt = 0, checks_done = 0;

  // Free-running 10 MHz clock
  always #50 aclk = ~aclk;

  ndi_init u_ndi_init (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .skip_init_strap(st[0]),
    .small_page_strap(st[1]), .small_page_wide_strap(st[2]),
    .short_row_strap(st[3]), .no_first_page_load_strap(st[4]),
    .dedicated_pins(1'b1), .nand_adq_i, .nand_adq_o, .nand_adq_oe_n,
    .nand_ale, .nand_cle, .nand_we_n, .nand_re_n, .nand_ce_n, .nand_wp_n,
    .nand_rdy_busy);
  // every flash pin but write protect, the drive enable, the upper data out byte and the upper three chip enables goes to the one partner
  ndi_flash_model u_ndi_flash_model (.aclk, .aresetn, .onfi_m,
    .ce_n(nand_ce_n[0]), .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n),
    .re_n(nand_re_n), .dq_o(nand_adq_o[7:0]), .dq_i(nand_adq_i),
    .rdy(nand_rdy_busy), .cmd_cnt, .adr_b0);

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Reset with new straps, poll for done, compare the outcome
  task run(input logic [4:0] s, input logic om, input logic [7:0] nc,
    input logic [7:0] na, input logic [2:0] fl);
    int n;
    st <= s;
    onfi_m <= om;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (d[0] !== 1'b1 && n < 4000);
    chk(32'({d[12:8], d[4], d[3:0]}), 32'({s, ~s[4] & ~s[0], fl, 1'b1}));
    chk(32'(cmd_cnt), 32'(nc));
    chk(32'(adr_b0), 32'(na));
    rd(OFS_INTR);
    chk(32'(d[0]), 32'h1);
    $display("Test straps %b finished", s);
  endtask

  task test_done;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    test_done;
  end

  initial begin
    run(5'b10001, 1'b1, 8'd1, 8'd0, 3'b000);
    run(5'b10000, 1'b1, 8'd4, 8'd0, 3'b001);
    run(5'b10000, 1'b0, 8'd5, 8'd0, 3'b010);
    run(5'b00000, 1'b1, 8'd6, 8'd5, 3'b001);
    run(5'b01000, 1'b1, 8'd6, 8'd4, 3'b001);
    run(5'b00110, 1'b1, 8'd3, 8'd0, 3'b110);
    rd(OFS_DRDATA);
    rd(OFS_STATUS);
    rd(OFS_DRDATA);
    chk(d, 32'h0000_0100);
    wr(OFS_INTR, 32'h1);
    rd(OFS_INTR);
    chk(32'(d[0]), 32'h0);
    wr(8'h1C, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(8'h1C);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(OFS_TIMING);
    chk(32'(d[3:0]), 32'(TW_RST));
    wr(OFS_CTRL, 32'h7);
    rd(OFS_CTRL);
    chk(32'(d[2:0]), 32'h4);
    chk(32'(nand_wp_n), 32'h1);
    $display("Test registers finished");
    test_done;
  end
endmodule // ndi_init_tb
